// File: logic/ooe_pkg.sv
// package: sizes, micro-op and pool entry layouts of the out-of-order engine
package ooe_pkg;
   localparam int ROB_N = 40;
   localparam int TAG_W = 6;
   localparam int LOG_N = 16;
   localparam int LOG_W = 4;
   localparam int DAT_W = 32;
   localparam int ADR_W = 32;
   localparam int OP_W = 8;
   localparam int ALLOC_W = 3;
   localparam int RET_W = 3;
   localparam int DISP_N = 6;
   localparam int PICK_N = 7;
   // dispatch lanes and writeback ports share one numbering
   localparam int P_INT0 = 0;
   localparam int P_INT1 = 1;
   localparam int P_FP0 = 2;
   localparam int P_FP1 = 3;
   localparam int P_LD = 4;
   localparam int P_ST = 5;
   localparam int P_BRO = 6;

   typedef enum logic [2:0] {
      C_INT = 3'h0,
      C_BR = 3'h1,
      C_FP = 3'h2,
      C_LD = 3'h3,
      C_STA = 3'h4,
      C_STD = 3'h5
   } ooe_cls_t;

   typedef struct packed {
      ooe_cls_t cls;
      logic [OP_W-1:0] op;
      logic has_dst;
      logic [LOG_W-1:0] dst;
      logic has_s0;
      logic [LOG_W-1:0] s0;
      logic has_s1;
      logic [LOG_W-1:0] s1;
      logic [ADR_W-1:0] tgt;
      logic [ADR_W-1:0] alt;
   } ooe_uop_t;

   typedef struct packed {
      logic valid;
      logic done;
      logic issued;
      logic fault;
      ooe_cls_t cls;
      logic [OP_W-1:0] op;
      logic has_dst;
      logic [LOG_W-1:0] dst;
      logic s0_rob;
      logic [TAG_W-1:0] s0_tag;
      logic [LOG_W-1:0] s0_log;
      logic s1_rob;
      logic [TAG_W-1:0] s1_tag;
      logic [LOG_W-1:0] s1_log;
      logic [DAT_W-1:0] data;
      logic [ADR_W-1:0] tgt;
      logic [ADR_W-1:0] alt;
   } ooe_ent_t;

   typedef struct packed {
      logic on;
      logic [TAG_W-1:0] tag;
   } ooe_map_t;

   typedef struct packed {
      logic valid;
      logic [TAG_W-1:0] tag;
      logic [OP_W-1:0] op;
      logic [DAT_W-1:0] a;
      logic [DAT_W-1:0] b;
      logic [DAT_W-1:0] c;
      logic [ADR_W-1:0] tgt;
      logic [ADR_W-1:0] alt;
   } ooe_disp_t;

   typedef struct packed {
      logic valid;
      logic [TAG_W-1:0] tag;
      logic [DAT_W-1:0] data;
      logic fault;
      logic mis;
   } ooe_wb_t;

   typedef struct packed {
      logic valid;
      logic we;
      logic store;
      logic [LOG_W-1:0] dst;
      logic [DAT_W-1:0] data;
   } ooe_ret_t;
endpackage

// File: logic/ooe_pick_if.sv
// interface: request vector in, oldest grant out
`timescale 1ns/10ps
interface ooe_pick_if;
   logic [ooe_pkg::ROB_N-1:0] req;
   logic [ooe_pkg::TAG_W-1:0] base;
   logic [ooe_pkg::ROB_N-1:0] gnt;
   logic [ooe_pkg::TAG_W-1:0] idx;
   logic found;
   modport user (output req, output base, input gnt, input idx, input found);
   modport picker (input req, input base, output gnt, output idx, output found);
endinterface

// File: logic/ooe_pick.sv
// oldest-first picker over the circular pool
`timescale 1ns/10ps
module ooe_pick (
   ooe_pick_if.picker pk
);
   always_comb begin
      int j;
      j = 0;
      pk.gnt = '0;
      pk.idx = '0;
      pk.found = 1'b0;
      // walk from the head, so the first hit is the oldest
      for (int a = 0; a < ooe_pkg::ROB_N; a++) begin
         j = (int'(pk.base) + a) % ooe_pkg::ROB_N;
         if (!pk.found && pk.req[j]) begin
            pk.found = 1'b1;
            pk.gnt[j] = 1'b1;
            pk.idx = ooe_pkg::TAG_W'(j);
         end
      end
   end
endmodule // ooe_pick

// File: logic/ooe_core.sv
// out-of-order core: rename, reorder pool, dispatch, recovery, retirement
//
// Overview of operation
// - the reorder pool holds 40 micro-ops, waiting or executed but uncommitted
// - micro-ops enter the pool in program order, lane order, no reordering
// - logical registers rename onto 40 physical registers, the pool entries
// - allocation attaches cleared status bits to each micro-op before writing it
// - dispatch needs all sources available and a free unit, any program order
// - competing ready micro-ops of one type are picked oldest first
// - at most six dispatches per clock: two integer, two fp, one load, one store
// - results are written into the micro-op's entry and held until retirement
// - only integer unit zero executes branches and reports mispredictions
// - a correctly predicted branch leaves younger work usable and continuing
// - a misprediction removes all younger micro-ops and redirects fetch correctly
// - loads are one micro-op, stores an address and a data micro-op
// - memory unit takes a store pair together, plus a load, same clock
// - stores go strictly in order, never speculative; loads may pass and speculate
// - retire only completed micro-ops in order, honouring faults, interrupts, mispredictions
// - at most three micro-ops retire per clock
// - retirement writes the sixteen architectural registers or memory, then frees entries
// - each micro-op has at most two sources and one destination
`timescale 1ns/10ps
module ooe_core (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ooe_pkg::ALLOC_W-1:0] dec_valid,
   input ooe_pkg::ooe_uop_t [ooe_pkg::ALLOC_W-1:0] dec_uop,
   output logic dec_ready,
   input wire logic [ooe_pkg::DISP_N-1:0] unit_free,
   output ooe_pkg::ooe_disp_t [ooe_pkg::DISP_N-1:0] disp,
   input ooe_pkg::ooe_wb_t [ooe_pkg::DISP_N-1:0] wb,
   input wire logic irq_req,
   output logic irq_ack,
   output logic redir_valid,
   output logic [ooe_pkg::ADR_W-1:0] redir_addr,
   output logic fault_valid,
   output logic [ooe_pkg::TAG_W-1:0] fault_tag,
   output ooe_pkg::ooe_ret_t [ooe_pkg::RET_W-1:0] ret
);
   localparam int N = ooe_pkg::ROB_N;
   localparam int TW = ooe_pkg::TAG_W;

   typedef struct packed {
      ooe_pkg::ooe_ent_t [N-1:0] rob;
      ooe_pkg::ooe_map_t [ooe_pkg::LOG_N-1:0] map;
      logic [ooe_pkg::LOG_N-1:0][ooe_pkg::DAT_W-1:0] arf;
      logic [TW-1:0] head;
      logic [TW-1:0] tail;
      logic [TW-1:0] cnt;
      ooe_pkg::ooe_disp_t [ooe_pkg::DISP_N-1:0] disp;
      ooe_pkg::ooe_ret_t [ooe_pkg::RET_W-1:0] ret;
      logic redir_v;
      logic [ooe_pkg::ADR_W-1:0] redir_a;
      logic flt_v;
      logic [TW-1:0] flt_tag;
      logic irq_ack;
   } ooe_core_st_t;

   ooe_core_st_t r_reg;
   ooe_core_st_t r_next;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [TW-1:0] wrap(input int v);
      return TW'(v % N);
   endfunction

   function automatic int age(input logic [TW-1:0] i);
      return (int'(i) + N - int'(r_reg.head)) % N;
   endfunction

   function automatic logic src_ok(input logic f, input logic [TW-1:0] t);
      return !f || r_reg.rob[t].done;
   endfunction

   function automatic logic [ooe_pkg::DAT_W-1:0] opv(input logic f, input logic [TW-1:0] t,
                                                    input logic [ooe_pkg::LOG_W-1:0] l);
      // a source not held in the pool is final in the architectural file
      return f ? r_reg.rob[t].data : r_reg.arf[l];
   endfunction

   function automatic ooe_pkg::ooe_disp_t mk(input logic [TW-1:0] j, input logic [ooe_pkg::DAT_W-1:0] c);
      ooe_pkg::ooe_disp_t d;
      d = '0;
      d.valid = 1'b1;
      d.tag = j;
      d.op = r_reg.rob[j].op;
      d.a = opv(r_reg.rob[j].s0_rob, r_reg.rob[j].s0_tag, r_reg.rob[j].s0_log);
      d.b = opv(r_reg.rob[j].s1_rob, r_reg.rob[j].s1_tag, r_reg.rob[j].s1_log);
      d.c = c;
      d.tgt = r_reg.rob[j].tgt;
      d.alt = r_reg.rob[j].alt;
      return d;
   endfunction

   // ************************************************************
   // readiness and oldest-first pickers
   // ************************************************************
   logic [N-1:0] rdy;
   logic [N-1:0] rq_int;
   logic [N-1:0] rq_br;
   logic [N-1:0] rq_fp;
   logic [N-1:0] rq_ld;
   logic [N-1:0] sta_pend;
   logic [N-1:0] br_open;
   logic [ooe_pkg::PICK_N-1:0][N-1:0] pk_req;
   logic [ooe_pkg::PICK_N-1:0][N-1:0] pk_gnt;
   logic [ooe_pkg::PICK_N-1:0][TW-1:0] pk_idx;
   logic [ooe_pkg::PICK_N-1:0] pk_found;
   logic st_ok;
   logic [TW-1:0] std_j;

   always_comb begin
      for (int i = 0; i < N; i++) begin
         rdy[i] = r_reg.rob[i].valid && !r_reg.rob[i].issued &&
                  src_ok(r_reg.rob[i].s0_rob, r_reg.rob[i].s0_tag) &&
                  src_ok(r_reg.rob[i].s1_rob, r_reg.rob[i].s1_tag);
         rq_int[i] = rdy[i] && r_reg.rob[i].cls == ooe_pkg::C_INT;
         rq_br[i] = rdy[i] && r_reg.rob[i].cls == ooe_pkg::C_BR;
         rq_fp[i] = rdy[i] && r_reg.rob[i].cls == ooe_pkg::C_FP;
         rq_ld[i] = rdy[i] && r_reg.rob[i].cls == ooe_pkg::C_LD;
         sta_pend[i] = r_reg.rob[i].valid && !r_reg.rob[i].issued && r_reg.rob[i].cls == ooe_pkg::C_STA;
         br_open[i] = r_reg.rob[i].valid && !r_reg.rob[i].done && r_reg.rob[i].cls == ooe_pkg::C_BR;
      end
   end

   assign pk_req[ooe_pkg::P_INT0] = (rq_int | rq_br) & {N{unit_free[ooe_pkg::P_INT0]}};
   assign pk_req[ooe_pkg::P_INT1] = rq_int & ~pk_gnt[ooe_pkg::P_INT0];
   assign pk_req[ooe_pkg::P_FP0] = rq_fp & {N{unit_free[ooe_pkg::P_FP0]}};
   assign pk_req[ooe_pkg::P_FP1] = rq_fp & ~pk_gnt[ooe_pkg::P_FP0];
   assign pk_req[ooe_pkg::P_LD] = rq_ld;
   assign pk_req[ooe_pkg::P_ST] = sta_pend;
   assign pk_req[ooe_pkg::P_BRO] = br_open;

   ooe_pick_if pk[ooe_pkg::PICK_N] ();
   for (genvar g = 0; g < ooe_pkg::PICK_N; g++) begin : g_pick
      assign pk[g].req = pk_req[g];
      assign pk[g].base = r_reg.head;
      assign pk_gnt[g] = pk[g].gnt;
      assign pk_idx[g] = pk[g].idx;
      assign pk_found[g] = pk[g].found;
      ooe_pick u_pick (.pk(pk[g]));
   end

   // only the oldest unissued store may go, and only with no older open branch
   assign std_j = wrap(int'(pk_idx[ooe_pkg::P_ST]) + 1);
   assign st_ok = pk_found[ooe_pkg::P_ST] && rdy[pk_idx[ooe_pkg::P_ST]] && rdy[std_j] &&
                  r_reg.rob[std_j].cls == ooe_pkg::C_STD &&
                  (!pk_found[ooe_pkg::P_BRO] ||
                   age(pk_idx[ooe_pkg::P_ST]) < age(pk_idx[ooe_pkg::P_BRO]));

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      int t;
      int j;
      int nret;
      int nal;
      int base_cnt;
      logic mis;
      logic [TW-1:0] mtag;
      logic stop;
      logic flt;
      logic irq;
      ooe_pkg::ooe_ent_t e;
      ooe_pkg::ooe_uop_t u;
      t = 0;
      j = 0;
      nret = 0;
      nal = 0;
      mis = 1'b0;
      mtag = '0;
      stop = 1'b0;
      flt = 1'b0;
      irq = 1'b0;
      e = '0;
      u = '0;
      r_next = r_reg;
      r_next.disp = '0;
      r_next.ret = '0;
      r_next.redir_v = 1'b0;
      r_next.flt_v = 1'b0;
      r_next.irq_ack = 1'b0;
      base_cnt = int'(r_reg.cnt);

      // writeback; stale answers for freed or unissued entries are dropped
      for (int k = 0; k < ooe_pkg::DISP_N; k++) begin
         t = int'(wb[k].tag);
         if (wb[k].valid && t < N && r_reg.rob[t].valid && r_reg.rob[t].issued && !r_reg.rob[t].done) begin
            r_next.rob[t].done = 1'b1;
            r_next.rob[t].data = wb[k].data;
            r_next.rob[t].fault = wb[k].fault;
            if (k == ooe_pkg::P_ST) begin
               r_next.rob[wrap(t + 1)].done = 1'b1;
            end
            // a correct prediction just completes; younger work stays valid
            if (k == ooe_pkg::P_INT0 && r_reg.rob[t].cls == ooe_pkg::C_BR && wb[k].mis) begin
               mis = 1'b1;
               mtag = TW'(t);
            end
         end
      end

      // dispatch from the current pool image
      for (int k = 0; k < ooe_pkg::P_ST; k++) begin
         if (pk_found[k] && unit_free[k]) begin
            r_next.rob[pk_idx[k]].issued = 1'b1;
            r_next.disp[k] = mk(pk_idx[k], '0);
         end
      end
      if (st_ok && unit_free[ooe_pkg::P_ST]) begin
         r_next.rob[pk_idx[ooe_pkg::P_ST]].issued = 1'b1;
         r_next.rob[std_j].issued = 1'b1;
         r_next.disp[ooe_pkg::P_ST] = mk(pk_idx[ooe_pkg::P_ST],
                                         opv(r_reg.rob[std_j].s0_rob, r_reg.rob[std_j].s0_tag,
                                             r_reg.rob[std_j].s0_log));
      end

      // misprediction: drop everything younger and rebuild the rename map
      if (mis) begin
         r_next.redir_v = 1'b1;
         r_next.redir_a = r_reg.rob[mtag].alt;
         r_next.tail = wrap(int'(mtag) + 1);
         base_cnt = age(mtag) + 1;
         r_next.map = '0;
         for (int a = 0; a < N; a++) begin
            j = (int'(r_reg.head) + a) % N;
            if (a > age(mtag)) begin
               r_next.rob[j].valid = 1'b0;
            end else if (r_next.rob[j].valid && r_next.rob[j].has_dst) begin
               r_next.map[r_next.rob[j].dst] = {1'b1, TW'(j)};
            end
         end
      end

      // retirement, oldest first, stopping at the first entry not ready
      for (int q = 0; q < ooe_pkg::RET_W; q++) begin
         j = (int'(r_reg.head) + q) % N;
         e = r_reg.rob[j];
         if (!stop && !irq_req && e.valid && e.done && !e.fault) begin
            r_next.ret[q] = {1'b1, e.has_dst, e.cls == ooe_pkg::C_STA, e.dst, e.data};
            if (e.has_dst) begin
               r_next.arf[e.dst] = e.data;
               if (r_next.map[e.dst].on && r_next.map[e.dst].tag == TW'(j)) begin
                  r_next.map[e.dst].on = 1'b0;
               end
            end
            // consumers now find this value in the architectural file
            for (int i = 0; i < N; i++) begin
               if (r_next.rob[i].s0_rob && r_next.rob[i].s0_tag == TW'(j)) begin
                  r_next.rob[i].s0_rob = 1'b0;
               end
               if (r_next.rob[i].s1_rob && r_next.rob[i].s1_tag == TW'(j)) begin
                  r_next.rob[i].s1_rob = 1'b0;
               end
            end
            r_next.rob[j] = '0;
            r_next.head = wrap(j + 1);
            nret = nret + 1;
         end else begin
            if (!stop && e.valid && e.done && e.fault) begin
               flt = 1'b1;
               r_next.flt_tag = TW'(j);
            end
            stop = 1'b1;
         end
      end
      irq = irq_req && !flt;

      // fault or interrupt: nothing past the committed point survives
      if (flt || irq) begin
         r_next.flt_v = flt;
         r_next.irq_ack = irq;
         r_next.redir_v = 1'b0;
         for (int i = 0; i < N; i++) begin
            r_next.rob[i].valid = 1'b0;
         end
         r_next.map = '0;
         r_next.tail = r_next.head;
         base_cnt = nret;
      end

      // allocation waits for room for a whole group and for a quiet pool
      dec_ready = int'(r_reg.cnt) <= N - ooe_pkg::ALLOC_W && !mis && !irq_req && !flt;
      if (dec_ready) begin
         for (int l = 0; l < ooe_pkg::ALLOC_W; l++) begin
            if (dec_valid[l]) begin
               u = dec_uop[l];
               j = int'(r_next.tail);
               e = '0;
               e.valid = 1'b1;
               e.cls = u.cls;
               e.op = u.op;
               e.has_dst = u.has_dst;
               e.dst = u.dst;
               e.tgt = u.tgt;
               e.alt = u.alt;
               e.s0_log = u.has_s0 ? u.s0 : '0;
               e.s1_log = u.has_s1 ? u.s1 : '0;
               e.s0_rob = u.has_s0 && r_next.map[u.s0].on;
               e.s0_tag = r_next.map[u.s0].tag;
               e.s1_rob = u.has_s1 && r_next.map[u.s1].on;
               e.s1_tag = r_next.map[u.s1].tag;
               r_next.rob[j] = e;
               if (u.has_dst) begin
                  r_next.map[u.dst] = {1'b1, TW'(j)};
               end
               r_next.tail = wrap(j + 1);
               nal = nal + 1;
            end
         end
      end
      r_next.cnt = TW'(base_cnt - nret + nal);

      // a dispatch whose entry was just flushed never leaves
      for (int k = 0; k < ooe_pkg::DISP_N; k++) begin
         if (!r_next.rob[r_next.disp[k].tag].valid) begin
            r_next.disp[k].valid = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign disp = r_reg.disp;
   assign ret = r_reg.ret;
   assign redir_valid = r_reg.redir_v;
   assign redir_addr = r_reg.redir_a;
   assign fault_valid = r_reg.flt_v;
   assign fault_tag = r_reg.flt_tag;
   assign irq_ack = r_reg.irq_ack;
endmodule // ooe_core

// File: verif/ooe_core_properties.sv
// checker: port-level properties of the out-of-order core
`timescale 1ns/10ps
module ooe_core_properties (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ooe_pkg::ALLOC_W-1:0] dec_valid,
   input ooe_pkg::ooe_uop_t [ooe_pkg::ALLOC_W-1:0] dec_uop,
   input wire logic dec_ready,
   input wire logic [ooe_pkg::DISP_N-1:0] unit_free,
   input ooe_pkg::ooe_disp_t [ooe_pkg::DISP_N-1:0] disp,
   input ooe_pkg::ooe_wb_t [ooe_pkg::DISP_N-1:0] wb,
   input wire logic irq_req,
   input wire logic irq_ack,
   input wire logic redir_valid,
   input wire logic [ooe_pkg::ADR_W-1:0] redir_addr,
   input wire logic fault_valid,
   input wire logic [ooe_pkg::TAG_W-1:0] fault_tag,
   input ooe_pkg::ooe_ret_t [ooe_pkg::RET_W-1:0] ret
);
   // ****************
   // properties
   // ****************
   logic [ooe_pkg::DISP_N-1:0] dv;
   logic [ooe_pkg::RET_W-1:0] rv;
   always_comb begin
      for (int k = 0; k < ooe_pkg::DISP_N; k++) dv[k] = disp[k].valid;
      for (int q = 0; q < ooe_pkg::RET_W; q++) rv[q] = ret[q].valid;
   end
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rstn);
   a_disp_free: assert property ((dv & ~$past(unit_free)) == '0)
      else $error("dispatch to a busy unit");
   a_irq_stall: assert property (irq_req |-> !dec_ready)
      else $error("decode open during interrupt");
   a_irq_quiet: assert property (irq_ack |-> rv == '0 && dv == '0)
      else $error("work left after interrupt");
   a_ack_cause: assert property (irq_ack |-> $past(irq_req))
      else $error("acknowledge without request");
   a_ret_packed: assert property (rv inside {3'h0, 3'h1, 3'h3, 3'h7})
      else $error("retirement out of order");
   a_redir_cause: assert property (redir_valid |-> $past(wb[0].valid && wb[0].mis))
      else $error("redirect without branch unit report");
   a_fault_flush: assert property (fault_valid |-> dv == '0 ##1 (rv == '0) [*2])
      else $error("work continued after fault");
   a_fault_stall: assert property (fault_valid |-> $past(!dec_ready))
      else $error("decode open at faulting head");
   a_reset_quiet: assert property ($rose(rstn) |-> dec_ready && rv == '0 && dv == '0)
      else $error("pool not empty after reset");
endmodule // ooe_core_properties

bind ooe_core ooe_core_properties i_ooe_core_properties (.clk, .rstn, .dec_valid, .dec_uop, .dec_ready, .unit_free,
   .disp, .wb, .irq_req, .irq_ack, .redir_valid, .redir_addr, .fault_valid, .fault_tag, .ret);

// File: verif/ooe_exec_model.sv
// model: execution units answering dispatches with writebacks
`timescale 1ns/10ps
module ooe_exec_model (
   input wire logic clk,
   input wire logic rstn,
   input ooe_pkg::ooe_disp_t [ooe_pkg::DISP_N-1:0] disp,
   input wire logic [ooe_pkg::DISP_N-1:0] allow,
   input wire logic slow,
   input wire logic mis_on,
   input wire logic fault_on,
   input wire logic drop,
   output logic [ooe_pkg::DISP_N-1:0] unit_free,
   output ooe_pkg::ooe_wb_t [ooe_pkg::DISP_N-1:0] wb
);
   // ****************
   // units
   // ****************
   ooe_pkg::ooe_disp_t [ooe_pkg::DISP_N-1:0] held_reg;
   logic [ooe_pkg::DISP_N-1:0] busy_reg;
   logic [1:0] wait_reg [ooe_pkg::DISP_N];
   // a unit shows busy in its dispatch cycle too, so no second pick lands on it
   always_comb
      for (int k = 0; k < ooe_pkg::DISP_N; k++) unit_free[k] = allow[k] & ~busy_reg[k] & ~disp[k].valid;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy_reg <= '0;
         wb <= '0;
      end else begin
         for (int k = 0; k < ooe_pkg::DISP_N; k++) begin
            // idle lanes toggle so stale data never passes for fresh
            wb[k] <= ~wb[k];
            wb[k].valid <= 1'b0;
            if (disp[k].valid) begin
               held_reg[k] <= disp[k];
               busy_reg[k] <= 1'b1;
               wait_reg[k] <= slow ? 2'h3 : 2'h0;
            end else if (drop) begin
               busy_reg[k] <= 1'b0;
            end else if (busy_reg[k] && wait_reg[k] != 2'h0) begin
               wait_reg[k] <= wait_reg[k] - 2'h1;
            end else if (busy_reg[k]) begin
               busy_reg[k] <= 1'b0;
               // store lane sums address and data operands in one answer
               wb[k] <= {1'b1, held_reg[k].tag, held_reg[k].a + held_reg[k].b + held_reg[k].c + 32'(held_reg[k].op),
                  fault_on && k == ooe_pkg::P_LD, mis_on && k == ooe_pkg::P_INT0};
            end
         end
      end
   end
endmodule // ooe_exec_model

// File: verif/ooe_core_bench.sv
// testbench: scenarios for the out-of-order core
`timescale 1ns/10ps
module ooe_core_bench;
   // ****************
   // harness
   // ****************
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] dec_valid = 3'h0;
   ooe_pkg::ooe_uop_t [2:0] dec_uop = '0;
   logic dec_ready;
   logic [5:0] unit_free;
   logic [5:0] allow = 6'h3f;
   ooe_pkg::ooe_disp_t [5:0] disp;
   ooe_pkg::ooe_wb_t [5:0] wb;
   logic irq_req = 1'b0;
   logic irq_ack;
   logic redir_valid;
   logic [31:0] redir_addr;
   logic fault_valid;
   logic [5:0] fault_tag;
   ooe_pkg::ooe_ret_t [2:0] ret;
   logic slow = 1'b0;
   logic mis_on = 1'b0;
   logic fault_on = 1'b0;
   int errors = 0;
   int comparisons = 0;
   int redirs = 0;
   int faults = 0;
   int acks = 0;
   logic [31:0] last_redir = 32'h0;
   logic [5:0] last_fault = 6'h0;
   ooe_pkg::ooe_uop_t no_uop = '0;
   logic [37:0] rq [$];

   ooe_core i_ooe_core (.clk, .rstn, .dec_valid, .dec_uop, .dec_ready, .unit_free, .disp, .wb, .irq_req, .irq_ack,
      .redir_valid, .redir_addr, .fault_valid, .fault_tag, .ret);
   ooe_exec_model i_ooe_exec_model (.clk, .rstn, .disp, .allow, .slow, .mis_on, .fault_on,
      .drop(redir_valid | fault_valid | irq_ack), .unit_free, .wb);

   initial begin
      forever #20 clk = ~clk;
   end

   always @(negedge clk) begin
      for (int q = 0; q < 3; q++)
         if (ret[q].valid === 1'b1)
            rq.push_back({ret[q].store, ret[q].we, ret[q].dst, ret[q].data});
      if (redir_valid === 1'b1) begin
         redirs++;
         last_redir = redir_addr;
      end
      faults += int'(fault_valid === 1'b1);
      if (fault_valid === 1'b1)
         last_fault = fault_tag;
      acks += int'(irq_ack === 1'b1);
   end

   task automatic complete_run;
      if (errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1) begin
         errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask

   // d and s: top bit says present; both sources name the same register
   function automatic ooe_pkg::ooe_uop_t u(input ooe_pkg::ooe_cls_t c, input logic [7:0] o, input logic [4:0] d,
      input logic [4:0] s);
      u = '{cls: c, op: o, has_dst: d[4], dst: d[3:0], has_s0: s[4], s0: s[3:0], has_s1: s[4], s1: s[3:0],
         tgt: 32'h0000_0100, alt: {24'h000012, o}};
   endfunction

   task automatic send(input logic [2:0] v, input ooe_pkg::ooe_uop_t [2:0] g, input int lim, output logic ok);
      int n;
      @(negedge clk);
      dec_valid = v;
      dec_uop = g;
      #1;
      n = 0;
      while (dec_ready !== 1'b1 && n < lim) begin
         @(negedge clk);
         #1;
         n++;
      end
      ok = (dec_ready === 1'b1);
      @(negedge clk);
      dec_valid = 3'h0;
   endtask

   task automatic put(input logic [2:0] v, input ooe_pkg::ooe_uop_t [2:0] g);
      logic ok;
      send(v, g, 300, ok);
      if (!ok) begin
         chk(1'b0, "decode wait ran out");
         complete_run;
      end
   endtask

   task automatic wait_ret(input int n);
      for (int i = 0; i < 500 && rq.size() < n; i++)
         @(negedge clk);
      if (rq.size() < n) begin
         chk(1'b0, "retire wait ran out");
         complete_run;
      end
      // extra cycles expose any retirement that should not happen
      repeat (20) @(negedge clk);
      chk(rq.size() == n, "retire count");
   endtask

   task automatic rchk(input int i, input logic we, input logic [3:0] d, input logic [31:0] v);
      chk(rq.size() > i && rq[i] === {1'b0, we, d, v}, "retired entry");
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic s_reset;
      rstn = 1'b0;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      #1;
      chk(dec_ready === 1'b1 && ret[0].valid === 1'b0 && disp[0].valid === 1'b0, "state after reset");
   endtask

   task automatic s_chain;
      rq.delete();
      put(3'h7, {u(ooe_pkg::C_FP, 8'h02, 5'h1a, 5'h12), u(ooe_pkg::C_INT, 8'h01, 5'h12, 5'h11),
         u(ooe_pkg::C_INT, 8'h05, 5'h11, 5'h00)});
      wait_ret(3);
      rchk(0, 1'b1, 4'h1, 32'h5);
      rchk(1, 1'b1, 4'h2, 32'hb);
      rchk(2, 1'b1, 4'ha, 32'h18);
   endtask

   task automatic s_order;
      rq.delete();
      allow = 6'h2f;
      put(3'h3, {no_uop, u(ooe_pkg::C_INT, 8'h03, 5'h14, 5'h00), u(ooe_pkg::C_LD, 8'h07, 5'h13, 5'h00)});
      repeat (12) @(negedge clk);
      chk(rq.size() == 0, "retired past a waiting load");
      allow = 6'h3f;
      wait_ret(2);
      rchk(0, 1'b1, 4'h3, 32'h7);
      rchk(1, 1'b1, 4'h4, 32'h3);
   endtask

   task automatic s_full;
      logic ok;
      int taken;
      rq.delete();
      allow = 6'h00;
      taken = 0;
      ok = 1'b1;
      for (int i = 0; i < ooe_pkg::ROB_N && ok; i++) begin
         send(3'h1, {3{u(ooe_pkg::C_INT, 8'(i), {2'b11, 3'(i)}, 5'h00)}}, 20, ok);
         taken += int'(ok);
      end
      chk(taken == ooe_pkg::ROB_N - ooe_pkg::ALLOC_W + 1, "pool capacity");
      allow = 6'h3f;
      wait_ret(taken);
      for (int i = 0; i < taken; i++)
         rchk(i, 1'b1, {1'b1, 3'(i)}, 32'(i));
   endtask

   task automatic s_branch(input logic mis);
      rq.delete();
      redirs = 0;
      mis_on = mis;
      put(3'h7, {u(ooe_pkg::C_INT, 8'h09, 5'h16, 5'h00), u(ooe_pkg::C_INT, 8'h08, 5'h15, 5'h00),
         u(ooe_pkg::C_BR, 8'h04, 5'h00, 5'h00)});
      wait_ret(mis ? 1 : 3);
      chk(redirs == int'(mis), "redirect count");
      if (mis)
         chk(last_redir === 32'h0000_1204 && rq[0][37:36] === 2'b00, "redirect target");
      else
         rchk(2, 1'b1, 4'h6, 32'h9);
      mis_on = 1'b0;
   endtask

   task automatic s_store;
      rq.delete();
      slow = 1'b1;
      put(3'h7, {u(ooe_pkg::C_LD, 8'h06, 5'h17, 5'h00), u(ooe_pkg::C_STD, 8'h00, 5'h00, 5'h11),
         u(ooe_pkg::C_STA, 8'h00, 5'h00, 5'h12)});
      wait_ret(3);
      chk(rq[0][37:36] === 2'b10 && rq[1][37:36] === 2'b00, "store pair retirement");
      rchk(2, 1'b1, 4'h7, 32'h6);
      slow = 1'b0;
   endtask

   task automatic s_irq;
      rq.delete();
      acks = 0;
      allow = 6'h00;
      put(3'h3, {no_uop, u(ooe_pkg::C_INT, 8'h02, 5'h12, 5'h00), u(ooe_pkg::C_INT, 8'h01, 5'h11, 5'h00)});
      irq_req = 1'b1;
      #1;
      chk(dec_ready === 1'b0, "decode open during interrupt");
      @(negedge clk);
      irq_req = 1'b0;
      allow = 6'h3f;
      wait_ret(0);
      chk(acks == 1, "interrupt acknowledge");
   endtask

   task automatic s_fault;
      rq.delete();
      faults = 0;
      fault_on = 1'b1;
      put(3'h3, {no_uop, u(ooe_pkg::C_INT, 8'h01, 5'h12, 5'h00), u(ooe_pkg::C_LD, 8'h03, 5'h11, 5'h00)});
      wait_ret(0);
      chk(faults == 1 && last_fault === 6'h0a, "fault report");
      fault_on = 1'b0;
   endtask

   initial begin
      s_reset;
      s_chain;
      s_order;
      s_full;
      s_branch(1'b0);
      s_branch(1'b1);
      s_store;
      s_irq;
      s_fault;
      s_reset;
      s_chain;
      complete_run;
   end
endmodule // ooe_core_bench
